// ==== hw/lcrc_regs.vh ====
// register offsets, field positions and reset values for the logic cell register control block
`ifndef LCRC_REGS_VH
`define LCRC_REGS_VH
`define LCRC_ADDR_W 4
`define LCRC_OFF_CTRL 4'h0
`define LCRC_OFF_CELL 4'h4
`define LCRC_OFF_MC 4'h8
`define LCRC_OFF_STAT 4'hC
`define LCRC_CTRL_RST 32'h00000000
`define LCRC_CELL_RST 32'h00000000
`define LCRC_MC_RST 32'h00000000
`define LCRC_CTRL_RSTEN 0
`define LCRC_CTRL_PRESET 1
`define LCRC_CTRL_EMUL 2
`define LCRC_CTRL_MODE 3
`define LCRC_CTRL_BYPASS 4
`define LCRC_CTRL_CLKSEL 5
`define LCRC_CTRL_FTYPE_LO 6
`define LCRC_CTRL_FTYPE_HI 7
`define LCRC_CTRL_BOTHEDGE 8
`define LCRC_CTRL_CASC 9
`define LCRC_CELL_SCLR 0
`define LCRC_CELL_SLOAD 1
`define LCRC_CELL_LDATA 2
`define LCRC_CELL_ACLR 3
`define LCRC_CELL_APRE 4
`define LCRC_CELL_CASCIN 5
`define LCRC_CELL_CIN 6
`define LCRC_CELL_DA 7
`define LCRC_CELL_DB 8
`define LCRC_CELL_LUTC_LO 16
`define LCRC_CELL_LUTC_HI 23
`define LCRC_CELL_LUTK_LO 24
`define LCRC_CELL_LUTK_HI 31
`define LCRC_MC_COMB 0
`define LCRC_MC_IN_A 1
`define LCRC_MC_IN_B 2
`define LCRC_MC_CE0 3
`define LCRC_MC_CE1 4
`define LCRC_MC_STEP 5
`define LCRC_FT_D 2'h0
`define LCRC_FT_T 2'h1
`define LCRC_FT_JK 2'h2
`define LCRC_FT_SR 2'h3
`endif

// ==== hw/lcrc_lookup3.v ====
// three-input lookup function with a programmable truth table
`timescale 1ns/1ps
module lcrc_lookup3
(
	// truth table
	input wire [7:0] TABLE,
	// selects
	input wire [2:0] SEL,
	// result
	output wire OUT
);
	assign OUT = TABLE[SEL];
endmodule

// ==== hw/lcrc_top.v ====
// logic cell and macrocell register control with a wishbone register port
`timescale 1ns/1ps
`include "lcrc_regs.vh"
module lcrc_top
(
	// clock and reset
	input wire CLOCK,
	input wire RST_N,
	// chip-wide reset pin
	input wire CHIP_RESET_N,
	// wishbone slave
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [3:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output wire WB_ACK_O,
	// cell and macrocell outputs
	output reg CELL_COMB_OUT,
	output reg CELL_REG_OUT,
	output reg CELL_CARRY_OUT,
	output reg MC_OUT
);
	reg [31:0] ctrl_reg;
	reg [31:0] cell_reg;
	reg [31:0] mc_reg;
	reg ack_reg;
	reg rstpin_meta_reg;
	reg rstpin_sync_reg;
	reg cell_q_reg;
	reg mc_q_reg;
	reg unknown_reg;
	reg cell_step_reg;
	reg mc_step_reg;
	reg [31:0] wr_next;
	wire bus_req;
	wire bus_wr;
	wire chip_rst;
	wire mode_counter;
	wire preset_mode;
	wire [2:0] lut_sel;
	wire cnt_data;
	wire carry_data;
	wire [1:0] ftype;
	wire clk_sel;
	wire clk_en;
	wire mc_comb;
	wire grp_clear;
	wire grp_preset;
	wire [5:0] status_bits;
	wire rd_req;
	wire cell_write;
	wire mc_step_write;
	reg cell_d_next;
	reg mc_q_next;

	assign bus_req = WB_CYC_I & WB_STB_I;
	assign bus_wr = bus_req & WB_WE_I & ~ack_reg;
	assign WB_ACK_O = ack_reg;
	// reads are taken on the request edge so the data register is settled while ack stands
	assign rd_req = bus_req & ~WB_WE_I & ~ack_reg;
	// any write to the cell register is one clock step of the cell
	assign cell_write = bus_wr & (WB_ADR_I == `LCRC_OFF_CELL);
	// only a step request in the low byte clocks the macrocell, so lane-masked writes do not step it
	assign mc_step_write = bus_wr & (WB_ADR_I == `LCRC_OFF_MC) & WB_SEL_I[0] & WB_DAT_I[`LCRC_MC_STEP];
	// live view of both registers and the cell's next value, read-only at the status offset
	assign status_bits = {clk_sel, unknown_reg, carry_data, cell_d_next, mc_q_reg, cell_q_reg};

	// byte-lane merge shared by all writable registers
	always @*
	begin
		wr_next = 32'h00000000;
		if (WB_ADR_I == `LCRC_OFF_CTRL)
			wr_next = ctrl_reg;
		else if (WB_ADR_I == `LCRC_OFF_CELL)
			wr_next = cell_reg;
		else if (WB_ADR_I == `LCRC_OFF_MC)
			wr_next = mc_reg;
		if (WB_SEL_I[0])
			wr_next[7:0] = WB_DAT_I[7:0];
		if (WB_SEL_I[1])
			wr_next[15:8] = WB_DAT_I[15:8];
		if (WB_SEL_I[2])
			wr_next[23:16] = WB_DAT_I[23:16];
		if (WB_SEL_I[3])
			wr_next[31:24] = WB_DAT_I[31:24];
	end

	// pin reset passes two flops before use
	always @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rstpin_meta_reg <= 1'b1;
			rstpin_sync_reg <= 1'b1;
		end
		else
		begin
			rstpin_meta_reg <= CHIP_RESET_N;
			rstpin_sync_reg <= rstpin_meta_reg;
		end
	end

	// the synchronised pin costs two cycles of latency but keeps every register update on one clock
	// chip reset only counts when enabled in control
	assign chip_rst = ~rstpin_sync_reg & ctrl_reg[`LCRC_CTRL_RSTEN];
	assign mode_counter = ctrl_reg[`LCRC_CTRL_MODE];
	assign preset_mode = ctrl_reg[`LCRC_CTRL_PRESET];
	assign ftype = ctrl_reg[`LCRC_CTRL_FTYPE_HI:`LCRC_CTRL_FTYPE_LO];
	// clock 1 is forced as the selected clock when both edges are in use
	assign clk_sel = ctrl_reg[`LCRC_CTRL_BOTHEDGE] ? 1'b1 : ctrl_reg[`LCRC_CTRL_CLKSEL];
	assign clk_en = clk_sel ? mc_reg[`LCRC_MC_CE1] : mc_reg[`LCRC_MC_CE0];
	assign grp_clear = cell_reg[`LCRC_CELL_ACLR];
	assign grp_preset = cell_reg[`LCRC_CELL_APRE];
	assign lut_sel = {cell_reg[`LCRC_CELL_CIN], cell_reg[`LCRC_CELL_DB], cell_reg[`LCRC_CELL_DA]};
	assign mc_comb = mc_reg[`LCRC_MC_COMB];

	// count data and fast carry from separate lookup functions
	lcrc_lookup3 u_count_lut
	(
		.TABLE(cell_reg[`LCRC_CELL_LUTC_HI:`LCRC_CELL_LUTC_LO]),
		.SEL(lut_sel),
		.OUT(cnt_data)
	);
	lcrc_lookup3 u_carry_lut
	(
		.TABLE(cell_reg[`LCRC_CELL_LUTK_HI:`LCRC_CELL_LUTK_LO]),
		.SEL(lut_sel),
		.OUT(carry_data)
	);

	// cell next value: clear beats load, both beat cascade
	always @*
	begin
		cell_d_next = cnt_data;
		if (mode_counter && ctrl_reg[`LCRC_CTRL_CASC])
			cell_d_next = cnt_data & cell_reg[`LCRC_CELL_CASCIN];
		if (mode_counter && cell_reg[`LCRC_CELL_SLOAD])
			cell_d_next = cell_reg[`LCRC_CELL_LDATA];
		if (mode_counter && cell_reg[`LCRC_CELL_SCLR])
			cell_d_next = 1'b0;
	end

	// macrocell register type
	always @*
	begin
		mc_q_next = mc_q_reg;
		case (ftype)
			`LCRC_FT_D: mc_q_next = mc_reg[`LCRC_MC_IN_A];
			`LCRC_FT_T: mc_q_next = mc_q_reg ^ mc_reg[`LCRC_MC_IN_A];
			`LCRC_FT_JK:
			begin
				case ({mc_reg[`LCRC_MC_IN_A], mc_reg[`LCRC_MC_IN_B]})
					2'h1: mc_q_next = 1'b0;
					2'h2: mc_q_next = 1'b1;
					2'h3: mc_q_next = ~mc_q_reg;
					default: mc_q_next = mc_q_reg;
				endcase
			end
			default:
			begin
				if (mc_reg[`LCRC_MC_IN_B])
					mc_q_next = 1'b0;
				else if (mc_reg[`LCRC_MC_IN_A])
					mc_q_next = 1'b1;
			end
		endcase
	end

	// wishbone registers; ack one cycle after request, dropped the next cycle
	always @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl_reg <= `LCRC_CTRL_RST;
			cell_reg <= `LCRC_CELL_RST;
			mc_reg <= `LCRC_MC_RST;
			ack_reg <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end
		else
		begin
			ack_reg <= bus_req & ~ack_reg;
			if (bus_wr)
			begin
				if (WB_ADR_I == `LCRC_OFF_CTRL)
					ctrl_reg <= wr_next;
				else if (WB_ADR_I == `LCRC_OFF_CELL)
					cell_reg <= wr_next;
				else if (WB_ADR_I == `LCRC_OFF_MC)
					mc_reg <= wr_next;
			end
			if (rd_req)
			begin
				if (WB_ADR_I == `LCRC_OFF_CTRL)
					WB_DAT_O <= ctrl_reg;
				else if (WB_ADR_I == `LCRC_OFF_CELL)
					WB_DAT_O <= cell_reg;
				else if (WB_ADR_I == `LCRC_OFF_MC)
					WB_DAT_O <= mc_reg;
				else if (WB_ADR_I == `LCRC_OFF_STAT)
					WB_DAT_O <= {26'h0000000, status_bits};
				else
					WB_DAT_O <= 32'h00000000;
			end
		end
	end

	// a clock step is a one-cycle pulse: any cell register write, or a macrocell write with the step bit set
	always @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cell_step_reg <= 1'b0;
			mc_step_reg <= 1'b0;
		end
		else
		begin
			cell_step_reg <= cell_write;
			mc_step_reg <= mc_step_write;
		end
	end

	// group clear and preset are levels: while either is set the cell cannot step
	// cell register: chip reset first, then group clear/preset, then clocked data
	always @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cell_q_reg <= 1'b0;
			unknown_reg <= 1'b1;
		end
		else if (chip_rst)
		begin
			cell_q_reg <= preset_mode;
			unknown_reg <= ctrl_reg[`LCRC_CTRL_EMUL];
		end
		else if (grp_clear)
		begin
			cell_q_reg <= 1'b0;
			unknown_reg <= 1'b0;
		end
		else if (grp_preset)
		begin
			cell_q_reg <= 1'b1;
			unknown_reg <= 1'b0;
		end
		else if (cell_step_reg)
		begin
			cell_q_reg <= cell_d_next;
			unknown_reg <= 1'b0;
		end
	end

	// the enable always follows the selected clock, it is never chosen on its own
	// macrocell register on the selected clock's enable
	always @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			mc_q_reg <= 1'b0;
		else if (chip_rst)
			mc_q_reg <= preset_mode;
		else if (mc_step_reg && clk_en)
			mc_q_reg <= mc_q_next;
	end

	// outputs from flops; both cell views at once
	always @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			CELL_COMB_OUT <= 1'b0;
			CELL_REG_OUT <= 1'b0;
			CELL_CARRY_OUT <= 1'b0;
			MC_OUT <= 1'b0;
		end
		else
		begin
			CELL_COMB_OUT <= cnt_data;
			CELL_REG_OUT <= cell_q_reg;
			CELL_CARRY_OUT <= carry_data;
			MC_OUT <= mc_comb ? mc_reg[`LCRC_MC_IN_A] : mc_q_reg;
		end
	end
endmodule

// ==== bench/lcrc_props.sv ====
// port checker for the logic cell register control block
`timescale 1ns/1ps
module lcrc_props
(
	// clock and reset
	input wire CLOCK,
	input wire RST_N,
	input wire CHIP_RESET_N,
	// bus and outputs
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [3:0] WB_ADR_I,
	input wire [31:0] WB_DAT_O,
	input wire WB_ACK_O,
	input wire CELL_COMB_OUT,
	input wire CELL_REG_OUT,
	input wire CELL_CARRY_OUT,
	input wire MC_OUT
);
	// cycles since the last write or chip reset; the cell, carry and macrocell outputs may only move shortly after one
	reg [2:0] age_reg;
	reg chip_reg;
	wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	always @(posedge CLOCK or negedge RST_N)
		if (!RST_N)
		begin
			age_reg <= 3'h7;
			chip_reg <= 1'b1;
		end
		else
		begin
			chip_reg <= CHIP_RESET_N;
			age_reg <= ((WB_ACK_O && WB_WE_I) || !CHIP_RESET_N || !chip_reg) ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
		end
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	a_ack_one_cycle: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("ack not a single pulse one cycle after request");
	a_ack_has_cause: assert property (WB_ACK_O |-> $past(req))
		else $error("ack without a request");
	a_unmapped_zero: assert property (req && WB_ADR_I[1:0] != 2'h0 && !WB_WE_I |=> WB_DAT_O == 32'h00000000)
		else $error("unmapped read not zero");
	a_data_holds: assert property ($changed(WB_DAT_O) |-> $past(req && !WB_WE_I))
		else $error("read data moved without a read");
	a_reset_zero: assert property ($rose(RST_N) |-> !CELL_REG_OUT && !MC_OUT && !CELL_COMB_OUT)
		else $error("outputs not clear after reset");
	a_cell_quiet: assert property (!$stable(CELL_REG_OUT) |-> age_reg < 3'h6)
		else $error("cell output moved with no cause");
	a_carry_quiet: assert property (!$stable(CELL_CARRY_OUT) |-> age_reg < 3'h6)
		else $error("carry moved with no cause");
	a_mc_quiet: assert property (!$stable(MC_OUT) |-> age_reg < 3'h6)
		else $error("macrocell output moved with no cause");
	c_write: cover property (req && WB_WE_I);
	c_read: cover property (req && !WB_WE_I);
	c_mc_rise: cover property ($rose(MC_OUT));
endmodule
bind lcrc_top lcrc_props lcrc_props_inst (.CLOCK(CLOCK), .RST_N(RST_N), .CHIP_RESET_N(CHIP_RESET_N),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .CELL_COMB_OUT(CELL_COMB_OUT), .CELL_REG_OUT(CELL_REG_OUT),
	.CELL_CARRY_OUT(CELL_CARRY_OUT), .MC_OUT(MC_OUT));

// ==== bench/tb_top.sv ====
// self-checking bench for the logic cell register control block
`timescale 1ns/1ps
`include "lcrc_regs.vh"
module tb_top;
	localparam [3:0] ct = `LCRC_OFF_CTRL;
	localparam [3:0] ce = `LCRC_OFF_CELL;
	localparam [3:0] mcr = `LCRC_OFF_MC;
	localparam [63:0] mcs = 64'h2A282A2A2E2C2A2C;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg chip_n = 1'b1;
	reg cyc = 1'b0;
	reg stb = 1'b0;
	reg we = 1'b0;
	reg [3:0] adr = 4'h0;
	reg [31:0] wdat = 32'h00000000;
	reg [31:0] got;
	wire [31:0] rdat;
	wire ack, comb_o, reg_o, carry_o, mc_o;
	integer err_count = 0;
	integer n_checks = 0;
	integer i;
	always #5 clock = ~clock;
	lcrc_top lcrc_top_inst (.CLOCK(clock), .RST_N(rst_n), .CHIP_RESET_N(chip_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.CELL_COMB_OUT(comb_o), .CELL_REG_OUT(reg_o), .CELL_CARRY_OUT(carry_o), .MC_OUT(mc_o));
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [63:0] name, input [31:0] exp, input [31:0] val);
		begin
			n_checks = n_checks + 1;
			if (val !== exp)
			begin
				err_count = err_count + 1;
				$display("unexpected %0s expected %h seen %h", name, exp, val);
			end
		end
	endtask
	// one classic cycle; release only at the edge where ack is seen
	task bus(input w, input [3:0] a, input [31:0] d);
		begin
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= d;
			@(posedge clock);
			while (ack !== 1'b1)
				@(posedge clock);
			got = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
			@(posedge clock);
		end
	endtask
	task rdc(input [3:0] a, input [31:0] exp);
		begin
			bus(1'b0, a, 32'h00000000);
			chk("readback", exp, got);
		end
	endtask
	// write, let the register step and the outputs settle, then compare status bits
	task st(input [3:0] a, input [31:0] d, input [5:0] m, input [5:0] e);
		begin
			bus(1'b1, a, d);
			repeat (3) @(posedge clock);
			bus(1'b0, `LCRC_OFF_STAT, 32'h00000000);
			chk("status", {26'h0, e}, got & {26'h0, m});
		end
	endtask
	initial
	begin
		#100000;
		err_count = err_count + 1;
		report_and_stop;
	end
	initial
	begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rdc(ct, `LCRC_CTRL_RST);
		rdc(ce, `LCRC_CELL_RST);
		rdc(mcr, `LCRC_MC_RST);
		st(ct, 32'h00000008, 6'h13, 6'h10);
		bus(1'b1, 4'h2, 32'hFFFFFFFF);
		rdc(4'h2, 32'h00000000);
		st(ce, 32'h00000006, 6'h01, 6'h01);
		st(ce, 32'h00000007, 6'h01, 6'h00);
		st(ce, 32'h018001C0, 6'h0D, 6'h05);
		st(ce, 32'h01800000, 6'h0D, 6'h08);
		chk("carry", 32'h00000001, {31'h0, carry_o});
		bus(1'b1, ct, 32'h00000208);
		st(ce, 32'h00000006, 6'h01, 6'h01);
		st(ce, 32'h0000000E, 6'h01, 6'h00);
		st(ce, 32'h00000012, 6'h01, 6'h01);
		bus(1'b1, ct, 32'h00000000);
		st(ce, 32'h00010000, 6'h01, 6'h01);
		chk("comb_out", 32'h00000001, {31'h0, comb_o});
		chk("reg_out", 32'h00000001, {31'h0, reg_o});
		for (i = 0; i < 8; i = i + 1)
		begin
			bus(1'b1, ct, {24'h000000, i[2:1], 6'h00});
			st(mcr, {24'h000000, mcs[8 * (7 - i) +: 8]}, 6'h02, {4'h0, ~i[0], 1'b0});
		end
		bus(1'b1, ct, 32'h00000000);
		st(mcr, 32'h00000032, 6'h02, 6'h00);
		bus(1'b1, ct, 32'h00000020);
		st(mcr, 32'h00000032, 6'h22, 6'h22);
		st(ct, 32'h00000100, 6'h20, 6'h20);
		bus(1'b1, ct, 32'h00000000);
		st(mcr, 32'h00000028, 6'h02, 6'h00);
		st(mcr, 32'h00000003, 6'h02, 6'h00);
		chk("mc_out", 32'h00000001, {31'h0, mc_o});
		bus(1'b1, ct, 32'h00000001);
		st(mcr, 32'h0000002A, 6'h03, 6'h03);
		chip_n <= 1'b0;
		repeat (4) @(posedge clock);
		st(mcr, 32'h0000002A, 6'h13, 6'h00);
		chip_n <= 1'b1;
		bus(1'b1, ct, 32'h00000007);
		chip_n <= 1'b0;
		repeat (4) @(posedge clock);
		st(mcr, 32'h00000028, 6'h13, 6'h13);
		chip_n <= 1'b1;
		report_and_stop;
	end
endmodule
